// File: logic/compass_sensor_readout.v
// Purpose: Host-side readout sequencer for a two-axis compass sensor IC,
//          external Z axis and a PWM tilt sensor
// Assumes: ADC handshake on the same clock; tilt PWM pins asynchronous
// Notes: One acquisition per request; offsets refreshed every few requests
`timescale 1ns/1ps
`include "compass_readout_defs.vh"

// ----------------------------------------
// Tilt PWM duty meter, one per channel
// ----------------------------------------
module tilt_pwm_meter #(
  parameter CNT_W = `PWM_CNT_W,
  parameter integer HALF_CYC = `PWM_HALF_CYC,
  parameter integer ANG_MUL = `ANG_MUL
) (
  // Clock and reset
  input wire clk,
  input wire rstN,
  // Pin and result
  input wire pwmPin,
  output reg signed [11:0] angle_r
);
  localparam integer LIM_I = `ANG_FULL_TENTHS;
  // Integer constants cut to the arithmetic widths on purpose
  localparam signed [CNT_W:0] HALF = HALF_CYC[CNT_W:0];
  localparam signed [15:0] MUL = ANG_MUL[15:0];
  localparam signed [11:0] LIM = LIM_I[11:0];
  reg [1:0] sync_r;
  reg prev_r;
  reg [CNT_W-1:0] highCnt_r;
  wire rise;
  wire signed [CNT_W:0] dev;
  wire signed [CNT_W+16:0] prod;
  wire signed [CNT_W+16:0] ang;

  // Pin synchroniser; only the second stage is looked at
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sync_r <= 2'h0;
      prev_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[0], pwmPin};
      prev_r <= sync_r[1];
    end
  end
  assign rise = sync_r[1] & ~prev_r;

  assign dev = $signed({1'b0, highCnt_r}) - HALF;
  assign prod = dev * MUL;
  assign ang = prod >>> `ANG_FRAC;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      highCnt_r <= {CNT_W{1'b0}};
      angle_r <= 12'sh000;
    end else if (rise) begin
      // Period boundary: convert last high time, clamp beyond 30..70 %
      highCnt_r <= {{(CNT_W-1){1'b0}}, 1'b1};
      if (ang > LIM)
        angle_r <= LIM;
      else if (ang < -LIM)
        angle_r <= -LIM;
      else
        angle_r <= ang[11:0];
    end else if (sync_r[1] && highCnt_r != {CNT_W{1'b1}}) begin
      highCnt_r <= highCnt_r + 1'b1; // Saturates if the pin sticks high
    end
  end
endmodule // tilt_pwm_meter

// ----------------------------------------
// Top level readout sequencer
// ----------------------------------------
module compass_sensor_readout #(
  parameter ADC_W = `ADC_W_DFLT,
  parameter [ADC_W-1:0] ZERO_CNT = `ZERO_CNT_DFLT,
  parameter [19:0] SR_WAIT_CYC = `SR_WAIT_US * `CLK_MHZ,
  parameter [19:0] SETTLE_CYC = `SETTLE_CYC_DFLT,
  parameter [7:0] CAL_EVERY = `CAL_EVERY_DFLT,
  parameter PWR_SAVE = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Request and results
  input wire acqStart,
  output reg busy_r,
  output reg magValid_r,
  output reg signed [ADC_W+2:0] magX_r,
  output reg signed [ADC_W+2:0] magY_r,
  output reg signed [ADC_W+2:0] magZ_r,
  output reg signed [11:0] pitch_r,
  output reg signed [11:0] roll_r,
  output reg fwdVertical_r,
  // Sensor pins
  output reg sensor_amp_supply_r,
  output reg strapPulse_r,
  output reg axisSelZ_r,
  // ADC handshake
  output reg adcStart_r,
  output reg adcChan_r,
  input wire adcDone,
  input wire [ADC_W-1:0] adcData,
  // Tilt PWM pins
  input wire pitchPwm,
  input wire rollPwm,
  input wire vertPwm
);
  localparam MW = ADC_W + 3;
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_SETTLE = 6'h02;
  localparam [5:0] S_SRWAIT = 6'h04;
  localparam [5:0] S_START = 6'h08;
  localparam [5:0] S_CONV = 6'h10;
  localparam [5:0] S_DONE = 6'h20;
  localparam integer VLIM_I = `VERT_LIM_TENTHS;
  localparam signed [11:0] VLIM = VLIM_I[11:0];

  reg [1:0] rstSync_r;
  wire rstN;
  reg [5:0] state_r;
  reg [19:0] waitCnt_r;
  reg [1:0] axis_r;
  reg phase_r;
  reg calRun_r;
  reg offValid_r;
  reg [7:0] acqCnt_r;
  reg [ADC_W-1:0] rstSmp_r [0:2];
  reg [ADC_W-1:0] setSmp_r [0:2];
  reg signed [MW-1:0] off_r [0:2];
  reg signed [MW-1:0] posD [0:2];
  reg signed [MW-1:0] negD [0:2];
  reg signed [MW-1:0] offNew [0:2];
  reg signed [MW-1:0] offUse [0:2];
  reg signed [MW-1:0] corr [0:2];
  wire signed [11:0] pitchAng;
  wire signed [11:0] rollAng;
  wire signed [11:0] vertAng;
  integer i;
  integer k; // Sequencer loop index, kept apart from the comb one

  // Reset release through two flops, assertion stays asynchronous
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      rstSync_r <= 2'h0;
    else
      rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstN = rstSync_r[1];

  // Tilt channels, free running between acquisitions
  tilt_pwm_meter u_pitch (.clk(clk), .rstN(rstN), .pwmPin(pitchPwm), .angle_r(pitchAng));
  tilt_pwm_meter u_roll (.clk(clk), .rstN(rstN), .pwmPin(rollPwm), .angle_r(rollAng));
  tilt_pwm_meter u_vert (.clk(clk), .rstN(rstN), .pwmPin(vertPwm), .angle_r(vertAng));

  // Offset arithmetic on the held samples
  always @* begin
    for (i = 0; i < 3; i = i + 1) begin
      posD[i] = $signed({3'b000, setSmp_r[i]}) - $signed({3'b000, ZERO_CNT});
      negD[i] = $signed({3'b000, rstSmp_r[i]}) - $signed({3'b000, ZERO_CNT});
      offNew[i] = (posD[i] + negD[i]) >>> 1;
      offUse[i] = calRun_r ? offNew[i] : off_r[i];
      corr[i] = posD[i] - offUse[i];
    end
  end

  // Acquisition sequencer
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= S_IDLE;
      waitCnt_r <= 20'h00000;
      axis_r <= `AXIS_X;
      phase_r <= 1'b0;
      calRun_r <= 1'b0;
      offValid_r <= 1'b0;
      acqCnt_r <= 8'h00;
      busy_r <= 1'b0;
      magValid_r <= 1'b0;
      magX_r <= {MW{1'b0}};
      magY_r <= {MW{1'b0}};
      magZ_r <= {MW{1'b0}};
      pitch_r <= 12'sh000;
      roll_r <= 12'sh000;
      fwdVertical_r <= 1'b0;
      sensor_amp_supply_r <= 1'b0;
      strapPulse_r <= 1'b1;
      axisSelZ_r <= 1'b0;
      adcStart_r <= 1'b0;
      adcChan_r <= 1'b0;
      for (k = 0; k < 3; k = k + 1) begin
        rstSmp_r[k] <= {ADC_W{1'b0}};
        setSmp_r[k] <= {ADC_W{1'b0}};
        off_r[k] <= {MW{1'b0}};
      end
    end else begin
      magValid_r <= 1'b0;
      adcStart_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (acqStart) begin
            busy_r <= 1'b1;
            sensor_amp_supply_r <= 1'b1;
            axisSelZ_r <= 1'b0;
            axis_r <= `AXIS_X;
            calRun_r <= ~offValid_r | (acqCnt_r == 8'h00);
            phase_r <= offValid_r & (acqCnt_r != 8'h00);
            waitCnt_r <= SETTLE_CYC;
            state_r <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          if (waitCnt_r != 20'h00000) begin
            waitCnt_r <= waitCnt_r - 1'b1;
          end else if (calRun_r && !phase_r && strapPulse_r) begin
            strapPulse_r <= 1'b0;
            waitCnt_r <= SR_WAIT_CYC;
            state_r <= S_SRWAIT;
          end else begin
            state_r <= S_START;
          end
        end
        S_SRWAIT: begin
          // Hold off conversions after strap edge
          if (waitCnt_r != 20'h00000)
            waitCnt_r <= waitCnt_r - 1'b1;
          else
            state_r <= S_START;
        end
        S_START: begin
          adcStart_r <= 1'b1;
          adcChan_r <= (axis_r != `AXIS_X);
          state_r <= S_CONV;
        end
        S_CONV: begin
          if (adcDone) begin
            if (phase_r)
              setSmp_r[axis_r] <= adcData;
            else
              rstSmp_r[axis_r] <= adcData;
            if (axis_r == `AXIS_X) begin
              axis_r <= `AXIS_Y;
              state_r <= S_START;
            end else if (axis_r == `AXIS_Y) begin
              axis_r <= `AXIS_Z;
              axisSelZ_r <= 1'b1;
              waitCnt_r <= SETTLE_CYC;
              state_r <= S_SETTLE;
            end else if (!phase_r) begin
              axisSelZ_r <= 1'b0;
              axis_r <= `AXIS_X;
              phase_r <= 1'b1;
              strapPulse_r <= 1'b1;
              // Edges spaced by full measurement pass
              waitCnt_r <= SR_WAIT_CYC;
              state_r <= S_SRWAIT;
            end else begin
              axisSelZ_r <= 1'b0;
              state_r <= S_DONE;
            end
          end
        end
        S_DONE: begin
          magX_r <= corr[0];
          magY_r <= corr[1];
          magZ_r <= corr[2];
          if (calRun_r) begin
            offValid_r <= 1'b1;
            for (k = 0; k < 3; k = k + 1)
              off_r[k] <= offNew[k];
          end
          // Tilt latched with the magnetic set
          pitch_r <= pitchAng;
          roll_r <= rollAng;
          // Upright when third axis near level
          fwdVertical_r <= (vertAng < VLIM) && (vertAng > -VLIM);
          acqCnt_r <= (acqCnt_r >= CAL_EVERY - 8'h01) ? 8'h00 : acqCnt_r + 8'h01;
          sensor_amp_supply_r <= (PWR_SAVE == 0);
          magValid_r <= 1'b1;
          busy_r <= 1'b0;
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // compass_sensor_readout

// File: logic/compass_readout_defs.vh
// Purpose: Shared constants for the compass sensor readout controller
// Assumes: 100 MHz system clock, 14-bit ADC, 100 Hz tilt PWM
// Notes: Timing figures kept in their own units; cycle counts derived
`ifndef COMPASS_READOUT_DEFS_VH
`define COMPASS_READOUT_DEFS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_MHZ 100
`define SR_WAIT_US 500
`define SETTLE_CYC_DFLT 200
`define CAL_EVERY_DFLT 8

// ----------------------------------------
// ADC and magnetic axes
// ----------------------------------------
`define ADC_W_DFLT 14
`define ZERO_CNT_DFLT 8192
`define AXIS_X 2'h0
`define AXIS_Y 2'h1
`define AXIS_Z 2'h2

// ----------------------------------------
// Tilt PWM decoding
// ----------------------------------------
`define PWM_RATE_HZ 100
`define PWM_PERIOD_CYC (`CLK_MHZ * 1000000 / `PWM_RATE_HZ)
`define PWM_HALF_CYC (`PWM_PERIOD_CYC / 2)
`define DUTY_SPAN_PCT 20
`define ANG_FULL_TENTHS 900
`define ANG_FRAC 20
`define ANG_MUL (`ANG_FULL_TENTHS * (1 << `ANG_FRAC) / (`PWM_PERIOD_CYC * `DUTY_SPAN_PCT / 100))
`define VERT_LIM_TENTHS 450
`define PWM_CNT_W 21

`endif

// File: tb/sensor_model.sv
// Purpose: Sensor bridge, shared ADC and tilt PWM model
// Assumes: Same clock as the controller
// Notes: Data is garbage while unpowered, pulsing or unsettled
`timescale 1ns/1ps
module sensor_model #(
  parameter PULSE_CYC = 10,
  parameter SETTLE = 4
) (
  // Clock
  input wire clk,
  // Controller pins
  input wire supply,
  input wire strap,
  input wire selZ,
  input wire adcStart,
  input wire adcChan,
  output reg adcDone = 1'b0,
  output reg [13:0] adcData = 14'h0,
  // Scene
  input wire [3:0] lat,
  input wire signed [13:0] fx,
  input wire signed [13:0] fy,
  input wire signed [13:0] fz,
  input wire vertOn,
  output wire pwm,
  output wire vpwm
);
  reg strapQ = 1'b1;
  reg setPhase = 1'b1;
  reg selQ = 1'b0;
  reg supQ = 1'b0;
  integer pulseCnt = 0;
  integer quiet = 0;
  integer waitCnt = 0;
  integer ph = 0;
  integer f, b, v;
  // ----
  // Behaviour
  // ----
  // Short period keeps the run brief
  assign pwm = ph < 100;
  assign vpwm = vertOn && pwm;
  always @(posedge clk) begin
    ph <= (ph + 1) % 400;
    strapQ <= strap;
    selQ <= selZ;
    supQ <= supply;
    if (strap != strapQ) begin
      setPhase <= strap;
      pulseCnt <= PULSE_CYC;
    end else if (pulseCnt > 0) begin
      pulseCnt <= pulseCnt - 1;
    end
    // Bridge output settles after a switch
    if (selZ != selQ || supply != supQ)
      quiet <= SETTLE - 1;
    else if (quiet > 0)
      quiet <= quiet - 1;
    // Released bus keeps toggling
    adcDone <= 1'b0;
    adcData <= ~adcData;
    if (adcStart) begin
      f = adcChan ? (selZ ? fz : fy) : fx;
      b = adcChan ? (selZ ? 9 : -25) : 40;
      v = 8192 + b + (setPhase ? f : -f);
      if (!supply || pulseCnt > 0 || quiet > 0)
        v = ~v;
      waitCnt <= lat;
    end else if (waitCnt > 0) begin
      waitCnt <= waitCnt - 1;
    end
    if (waitCnt == 1 && !adcStart) begin
      adcDone <= 1'b1;
      adcData <= v[13:0];
    end
  end
endmodule // sensor_model

// File: tb/compass_readout_asserts.sv
// Purpose: Port checks for the compass readout controller
// Assumes: One clock, rst_b active low
// Notes: Ages count cycles since strap change, or since select or supply change
`timescale 1ns/1ps
module compass_readout_asserts #(
  parameter [19:0] SR_WAIT_CYC = 20'hc350,
  parameter [19:0] SETTLE_CYC = 20'hc8
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Request side
  input wire acqStart,
  input wire busy_r,
  input wire magValid_r,
  // Sensor and ADC side
  input wire sensor_amp_supply_r,
  input wire strapPulse_r,
  input wire axisSelZ_r,
  input wire adcStart_r,
  input wire adcChan_r,
  input wire adcDone
);
  reg [19:0] srAge_r;
  reg [19:0] selAge_r;
  reg convOpen_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----
  // Helpers
  // ----
  // Saturating ages, so reset gives no false hits
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      srAge_r <= 20'hfffff;
      selAge_r <= 20'hfffff;
      convOpen_r <= 1'b0;
    end else begin
      srAge_r <= $changed(strapPulse_r) ? 20'h0 : srAge_r + {19'h0, ~&srAge_r};
      selAge_r <= ($changed(axisSelZ_r) || $changed(sensor_amp_supply_r)) ? 20'h0
        : selAge_r + {19'h0, ~&selAge_r};
      convOpen_r <= adcStart_r | (convOpen_r & ~adcDone);
    end
  end
  sequence reqTaken;
    acqStart && !busy_r && !magValid_r;
  endsequence
  sequence runOpen;
    busy_r && sensor_amp_supply_r;
  endsequence
  // ----
  // Assertions
  // ----
  AST_SR_WAIT:
    assert property (adcStart_r |-> srAge_r >= SR_WAIT_CYC - 20'h1) else $error("early conv");
  AST_STRAP_GAP:
    assert property ($rose(strapPulse_r) |-> srAge_r >= SR_WAIT_CYC) else $error("strap gap");
  AST_SUPPLY_ON:
    assert property (adcStart_r |-> sensor_amp_supply_r) else $error("conv unpowered");
  AST_TAKE:
    assert property (reqTaken |=> runOpen) else $error("request not taken");
  AST_PWR_DROP:
    assert property (magValid_r |-> !sensor_amp_supply_r) else $error("supply left on");
  AST_SEL_STABLE:
    assert property (convOpen_r |-> $stable(adcChan_r) && $stable(axisSelZ_r))
    else $error("select moved");
  AST_ONE_CONV:
    assert property (convOpen_r |-> !adcStart_r) else $error("overlapping conv");
  AST_VALID_END:
    assert property ($fell(busy_r) |-> magValid_r) else $error("busy ended silently");
  AST_SETTLE:
    assert property (adcStart_r |-> selAge_r >= SETTLE_CYC) else $error("unsettled conv");
endmodule // compass_readout_asserts

// File: tb/tb.sv
// Purpose: Self-checking bench for the compass readout controller
// Assumes: Strap and settle waits shortened by parameter
// Notes: Short tilt PWM period, so angles clamp
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg acqStart = 1'b0;
  reg vertOn = 1'b0;
  reg [3:0] lat = 4'h1;
  reg signed [13:0] fx = 14'h0, fy = 14'h0, fz = 14'h0;
  reg [96:0] rows [0:3];
  reg [16:0] ex, ey, ez;
  wire busy_r, magValid_r, fwdVertical_r, sensor_amp_supply_r, strapPulse_r;
  wire axisSelZ_r, adcStart_r, adcChan_r, adcDone, pwm, vpwm;
  wire signed [16:0] magX_r, magY_r, magZ_r;
  wire signed [11:0] pitch_r, roll_r;
  wire [13:0] adcData;
  integer failures = 0;
  integer checks_done = 0;
  integer i;
  compass_sensor_readout #(.SR_WAIT_CYC(20'h14), .SETTLE_CYC(20'h4), .CAL_EVERY(8'h2)) dut (
    .clk, .rst_b, .acqStart, .busy_r, .magValid_r, .magX_r, .magY_r, .magZ_r,
    .pitch_r, .roll_r, .fwdVertical_r, .sensor_amp_supply_r, .strapPulse_r, .axisSelZ_r,
    .adcStart_r, .adcChan_r, .adcDone, .adcData, .pitchPwm(pwm), .rollPwm(pwm),
    .vertPwm(vpwm));
  sensor_model model (.clk, .supply(sensor_amp_supply_r), .strap(strapPulse_r),
    .selZ(axisSelZ_r), .adcStart(adcStart_r), .adcChan(adcChan_r), .adcDone, .adcData,
    .lat, .fx, .fy, .fz, .vertOn, .pwm, .vpwm);
  // ----
  // Tasks
  // ----
  task chk(input [16:0] got, input [16:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Request, then bounded wait for the result pulse
  task acquire;
    integer n;
    begin
      n = 0;
      acqStart = 1'b1;
      @(posedge clk);
      #1 acqStart = 1'b0;
      while (magValid_r !== 1'b1 && n < 2000) begin
        @(posedge clk);
        #1 n = n + 1;
      end
      chk({magValid_r, busy_r}, 17'h2);
    end
  endtask
  task print_verdict;
    begin
      $display("checks=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    failures = failures + 1;
    print_verdict;
  end
  initial begin
    // Scene fields and latency, then the corrected axes they should give
    rows[0] = {14'h1f00, 14'h2100, 14'h0001, 4'h1, 17'h01f00, 17'h1e100, 17'h00001};
    rows[1] = {14'h0123, 14'h3fff, 14'h2100, 4'h9, 17'h00123, 17'h1ffff, 17'h1e100};
    rows[2] = {14'h2100, 14'h1f00, 14'h0000, 4'h9, 17'h1e100, 17'h01f00, 17'h00000};
    rows[3] = {14'h3e00, 14'h0200, 14'h1f00, 4'h1, 17'h1fe00, 17'h00200, 17'h01f00};
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    chk({strapPulse_r, sensor_amp_supply_r, busy_r, adcStart_r}, 17'h8);
    // Ordinary rows: calibrating and plain runs alternate
    for (i = 0; i < 4; i = i + 1) begin
      repeat (3) @(posedge clk);
      #1 {fx, fy, fz, lat, ex, ey, ez} = rows[i];
      acquire;
      chk(magX_r, ex);
      chk(magY_r, ey);
      chk(magZ_r, ez);
    end
    // Tilt clamp, vertical pick, request refused while busy
    repeat (1000) @(posedge clk);
    #1;
    fork
      acquire;
      begin
        repeat (8) @(posedge clk);
        #1 acqStart = 1'b1;
        @(posedge clk);
        #1 acqStart = 1'b0;
      end
    join
    chk(pitch_r, 17'h1fc7c);
    chk(roll_r, 17'h1fc7c);
    chk(fwdVertical_r, 17'h1);
    repeat (3) @(posedge clk);
    #1 chk(busy_r, 17'h0);
    vertOn = 1'b1;
    repeat (1000) @(posedge clk);
    #1 acquire;
    chk(fwdVertical_r, 17'h0);
    // Mid-run reset; outputs looked at once the reset has reached them
    acqStart = 1'b1;
    repeat (15) @(posedge clk);
    #1 rst_b = 1'b0;
    acqStart = 1'b0;
    #1 chk({strapPulse_r, sensor_amp_supply_r, busy_r, adcStart_r}, 17'h8);
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    // Fresh calibrating run after the reset
    repeat (3) @(posedge clk);
    #1 {fx, fy, fz, lat, ex, ey, ez} = rows[0];
    acquire;
    chk(magX_r, ex);
    chk(magY_r, ey);
    chk(magZ_r, ez);
    print_verdict;
  end
endmodule // tb

bind compass_sensor_readout compass_readout_asserts #(.SR_WAIT_CYC(SR_WAIT_CYC),
  .SETTLE_CYC(SETTLE_CYC)) uChk (.clk, .rst_b, .acqStart, .busy_r, .magValid_r,
  .sensor_amp_supply_r, .strapPulse_r, .axisSelZ_r, .adcStart_r, .adcChan_r, .adcDone);
